// ### common/fcsd_map.vh
// Register map, field positions, reset values and mode codes of the FIFO clear, sync detect and pin map block.
// Assumes inclusion by the core only; definitions only.
`ifndef FCSD_MAP_VH
`define FCSD_MAP_VH

// Byte offsets on the APB
`define FCSD_OFF_MODE       12'h000
`define FCSD_OFF_SYNC_CFG   12'h004
`define FCSD_OFF_SYNC_HI    12'h008
`define FCSD_OFF_SYNC_LO    12'h00c
`define FCSD_OFF_MAP_A      12'h010
`define FCSD_OFF_MAP_B      12'h014
`define FCSD_OFF_STATUS     12'h018
`define FCSD_OFF_IRQ_STAT   12'h01c
`define FCSD_OFF_IRQ_EN     12'h020
`define FCSD_OFF_IRQ_CLR    12'h024
`define FCSD_OFF_OVERRUN    12'h028

// Mode register fields
`define FCSD_MODE_LSB       0
`define FCSD_MODE_MSB       2
`define FCSD_PKT_BIT        3

// Sync configuration fields
`define FCSD_SIZE_LSB       0
`define FCSD_SIZE_MSB       2
`define FCSD_BSYNC_BIT      6
`define FCSD_SYNC_ON_BIT    7

// Interrupt bits
`define FCSD_IRQ_SYNC       0
`define FCSD_IRQ_OVERRUN    1
`define FCSD_IRQ_FLUSH      2
`define FCSD_IRQ_W          3

// Chip modes
`define FCSD_M_SLEEP        3'h0
`define FCSD_M_STDBY        3'h1
`define FCSD_M_SYNTH_READY_TX_MODE         3'h2
`define FCSD_M_TX           3'h3
`define FCSD_M_SYNTH_READY_RX_MODE         3'h4
`define FCSD_M_RX           3'h5

// Reset values; the core resets the mode register to 4'h9, not FCSD_RST_MODE
`define FCSD_RST_MODE       4'h1
`define FCSD_RST_SYNC_CFG   8'h83
`define FCSD_RST_SYNC_VAL   64'h0101010101010101
`define FCSD_RST_MAP_A      8'h00
`define FCSD_RST_MAP_B      4'h0

`endif

// ### core/fcsd_core.v
// FIFO flush control, sync word detector and general purpose pin mapping, with APB register access.
// Assumes status inputs and the demodulated bit stream come from logic on pclk; the FIFO itself is outside.
//
// Behaviour
// - Standby or sleep to transmit keeps FIFO.
// - Receive to standby or sleep keeps FIFO.
// - Flush entering receive from standby or sleep, receive-to-transmit, leaving transmit.
// - Standby and sleep swaps keep FIFO.
// - Sync detection only while enable bit set.
// - Sliding compare, match flag on full match.
// - First bit against MSB of first byte.
// - Clear match flag leaving receive or empty.
// - Sync length one to eight bytes.
// - Sixty-four bit pattern also drives transmit sync.
// - Six pins, two-bit code plus mode select.
// - Continuous receive code zero pin assignments.
// - Continuous pin two carries data in receive and transmit.
// - Packet code zero shows FIFO flags.
// - Packet data pin valid after receiver armed.
// - Overrun flag; writing one flushes FIFO.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fcsd_map.vh"

module fcsd_core (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Demodulated stream and FIFO events
    input  wire        rx_bit,
    input  wire        rx_bit_valid,
    input  wire        queue_write,
    // Internal status signals
    input  wire        bit_clock,
    input  wire        serial_data,
    input  wire        rx_timeout,
    input  wire        temp_or_battery_alert,
    input  wire        ref_clock_output,
    input  wire        mode_settled,
    input  wire        synth_locked,
    input  wire        signal_or_preamble_detect,
    input  wire        receiver_armed,
    input  wire        transmitter_armed,
    input  wire        queue_empty,
    input  wire        queue_full,
    input  wire        queue_threshold_hit,
    input  wire        payload_available,
    input  wire        checksum_valid,
    input  wire        frame_sent,
    input  wire        auto_sequence_active,
    // Control outputs
    output reg         fifo_flush,
    output reg  [2:0]  chip_mode,
    output reg         packet_mode,
    output reg         bit_sync_enable,
    output reg  [2:0]  sync_tx_length,
    output reg  [63:0] sync_tx_pattern,
    output reg         sync_match_flag,
    output reg         queue_overrun_flag,
    output reg         irq,
    // General purpose pins
    output reg  [5:0]  gp_pin
);

    reg  [7:0]                 sync_config_reg;
    reg  [7:0]                 pin_map_reg_a;
    reg  [3:0]                 pin_map_reg_b;
    reg  [`FCSD_IRQ_W-1:0]     irq_status;
    reg  [`FCSD_IRQ_W-1:0]     irq_enable;
    reg  [63:0]                sync_shift;
    reg                        empty_prev;
    reg  [31:0]                next_rdata;
    reg                        next_err;
    reg  [`FCSD_IRQ_W-1:0]     irq_set;
    wire [63:0]                next_shift;
    wire                       sync_detect_enable;
    wire                       in_rx;
    wire                       setup;
    wire                       wr_access;
    wire                       mode_wr;
    wire [2:0]                 new_mode;
    wire                       mode_flush;
    wire                       overrun_event;
    wire                       overrun_clr;
    wire                       match_now;
    wire                       match_clr;
    wire [11:0]                pin_codes;

    // Flush decision for a change from one mode to another
    function flush_needed;
        input [2:0] from_m;
        input [2:0] to_m;
        reg         from_low;
        begin
            from_low = (from_m == `FCSD_M_SLEEP) || (from_m == `FCSD_M_STDBY);
            flush_needed = 1'b0;
            if (from_m != to_m) begin
                if (from_low && to_m == `FCSD_M_RX)
                    flush_needed = 1'b1;
                else if (from_m == `FCSD_M_RX && to_m == `FCSD_M_TX)
                    flush_needed = 1'b1;
                else if (from_m == `FCSD_M_TX)
                    flush_needed = 1'b1;
            end
        end
    endfunction

    // Sync compare: only the low 8*length bits of the window take part
    function [63:0] len_mask;
        input [2:0] sz;
        reg   [5:0] sh;
        begin
            sh = {3'h7 - sz, 3'h0};
            len_mask = {64{1'b1}} >> sh;
        end
    endfunction

    function [63:0] aligned_pattern;
        input [63:0] val;
        input [2:0]  sz;
        reg   [5:0]  sh;
        begin
            sh = {3'h7 - sz, 3'h0};
            aligned_pattern = val >> sh;
        end
    endfunction

    // Pin values for one mapping code applied to all six pins
    function [5:0] pin_column;
        input [1:0] code;
        reg         pdata;
        begin
            pdata = serial_data & (receiver_armed | (chip_mode != `FCSD_M_RX));
            pin_column = 6'h00;
            if (!packet_mode) begin
                case (chip_mode)
                    `FCSD_M_STDBY, `FCSD_M_SYNTH_READY_TX_MODE, `FCSD_M_SYNTH_READY_RX_MODE: begin
                        case (code)
                            2'h0: pin_column = {ref_clock_output, temp_or_battery_alert, 4'h0};
                            2'h1: pin_column = (chip_mode == `FCSD_M_STDBY) ? 6'h00 :
                                               {synth_locked, synth_locked, 4'h0};
                            2'h2: pin_column = (chip_mode == `FCSD_M_STDBY) ? 6'h00 :
                                               {2'h0, auto_sequence_active, 3'h0};
                            default: pin_column = {mode_settled, mode_settled, temp_or_battery_alert, 3'h0};
                        endcase
                    end
                    `FCSD_M_RX: begin
                        case (code)
                            2'h0: pin_column = {ref_clock_output, temp_or_battery_alert, rx_timeout,
                                                serial_data, bit_clock, sync_match_flag};
                            2'h1: pin_column = {synth_locked, synth_locked, signal_or_preamble_detect,
                                                serial_data, signal_or_preamble_detect,
                                                signal_or_preamble_detect};
                            2'h2: pin_column = {signal_or_preamble_detect, rx_timeout, 1'b0,
                                                serial_data, 1'b0, receiver_armed};
                            default: pin_column = {mode_settled, mode_settled, temp_or_battery_alert,
                                                   serial_data, 2'h0};
                        endcase
                    end
                    `FCSD_M_TX: begin
                        case (code)
                            2'h0: pin_column = {ref_clock_output, temp_or_battery_alert, 1'b0,
                                                serial_data, bit_clock, transmitter_armed};
                            2'h1: pin_column = {synth_locked, synth_locked, 1'b0, serial_data, 2'h0};
                            2'h2: pin_column = {3'h0, serial_data, 2'h0};
                            default: pin_column = {mode_settled, mode_settled, temp_or_battery_alert,
                                                   serial_data, 2'h0};
                        endcase
                    end
                    default: pin_column = 6'h00;
                endcase
            end else begin
                // Packet operation: FIFO flags dominate pins 1 to 3
                case (code)
                    2'h0: pin_column = {ref_clock_output, temp_or_battery_alert, queue_empty,
                                        queue_full, queue_threshold_hit,
                                        (chip_mode == `FCSD_M_RX) ? payload_available :
                                        (chip_mode == `FCSD_M_TX) ? frame_sent : 1'b0};
                    2'h1: pin_column = {synth_locked, synth_locked, 4'h0} |
                                       {4'h0, queue_empty, 1'b0} |
                                       ((chip_mode == `FCSD_M_RX) ? {3'h0, receiver_armed, 1'b0, checksum_valid} :
                                        (chip_mode == `FCSD_M_TX) ? {2'h0, transmitter_armed, 3'h0} : 6'h00);
                    2'h2: pin_column = (chip_mode == `FCSD_M_RX) ?
                                       {pdata, rx_timeout, queue_empty, rx_timeout, queue_full, 1'b0} :
                                       (chip_mode == `FCSD_M_TX) ?
                                       {serial_data, 1'b0, queue_empty, queue_full, queue_full, 1'b0} :
                                       {2'h0, queue_empty, queue_full, queue_full, 1'b0};
                    // Receive shows the sync match on pin 2 in place of the full flag
                    default: pin_column = {mode_settled, 1'b0, queue_empty,
                                           (chip_mode == `FCSD_M_RX) ? sync_match_flag : queue_full, 1'b0,
                                           temp_or_battery_alert} |
                                          ((chip_mode == `FCSD_M_RX) ?
                                           {1'b0, signal_or_preamble_detect, 4'h0} : 6'h00);
                endcase
                // Sleep shows neither clocks nor synth nor mode-settled indications
                if (chip_mode == `FCSD_M_SLEEP)
                    pin_column = pin_column & 6'h0f;
                if ((chip_mode == `FCSD_M_SLEEP || chip_mode == `FCSD_M_STDBY) && code == 2'h1)
                    pin_column = pin_column & 6'h02;
                if (code == 2'h3 && chip_mode != `FCSD_M_RX)
                    pin_column = pin_column & 6'h2f;
            end
        end
    endfunction

    assign sync_detect_enable = sync_config_reg[`FCSD_SYNC_ON_BIT];
    assign in_rx              = (chip_mode == `FCSD_M_RX);
    assign setup              = psel & ~penable;
    assign wr_access          = psel & penable & pwrite & pready;
    assign mode_wr            = wr_access && paddr == `FCSD_OFF_MODE;
    assign new_mode           = pwdata[`FCSD_MODE_MSB:`FCSD_MODE_LSB];
    // Stdby/sleep swaps, stdby/sleep to tx and rx to stdby/sleep fall through as no flush
    assign mode_flush         = mode_wr && new_mode <= `FCSD_M_RX &&
                                flush_needed(chip_mode, new_mode);
    assign overrun_event      = queue_write & queue_full;
    assign overrun_clr        = wr_access && paddr == `FCSD_OFF_OVERRUN && pwdata[0];
    assign next_shift         = {sync_shift[62:0], rx_bit};
    assign match_now          = rx_bit_valid && sync_detect_enable && in_rx &&
                                (((next_shift ^ aligned_pattern(sync_tx_pattern,
                                  sync_config_reg[`FCSD_SIZE_MSB:`FCSD_SIZE_LSB])) &
                                  len_mask(sync_config_reg[`FCSD_SIZE_MSB:`FCSD_SIZE_LSB])) == 64'h0);
    assign match_clr          = (mode_wr && in_rx && new_mode < `FCSD_M_RX) ||
                                (queue_empty && !empty_prev);
    assign pin_codes          = {pin_map_reg_b, pin_map_reg_a};

    // Read mux and unmapped-address answer, captured in the setup cycle
    always @* begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (paddr)
            `FCSD_OFF_MODE:     next_rdata = {28'h0, packet_mode, chip_mode};
            `FCSD_OFF_SYNC_CFG: next_rdata = {24'h0, sync_config_reg};
            `FCSD_OFF_SYNC_HI:  next_rdata = sync_tx_pattern[63:32];
            `FCSD_OFF_SYNC_LO:  next_rdata = sync_tx_pattern[31:0];
            `FCSD_OFF_MAP_A:    next_rdata = {24'h0, pin_map_reg_a};
            `FCSD_OFF_MAP_B:    next_rdata = {28'h0, pin_map_reg_b};
            `FCSD_OFF_STATUS:   next_rdata = {24'h0, gp_pin, queue_overrun_flag, sync_match_flag};
            `FCSD_OFF_IRQ_STAT: next_rdata = {29'h0, irq_status};
            `FCSD_OFF_IRQ_EN:   next_rdata = {29'h0, irq_enable};
            `FCSD_OFF_IRQ_CLR:  next_rdata = 32'h0;
            `FCSD_OFF_OVERRUN:  next_rdata = {31'h0, queue_overrun_flag};
            default:            next_err   = 1'b1;
        endcase
    end

    // Per-pin selection from the four code columns; called from the clocked process so every
    // status input that pin_column reads is current, which an always @* would not guarantee
    function [5:0] select_pins;
        input [11:0] codes;
        reg   [5:0]  c0;
        reg   [5:0]  c1;
        reg   [5:0]  c2;
        reg   [5:0]  c3;
        integer      i;
        begin
            c0 = pin_column(2'h0);
            c1 = pin_column(2'h1);
            c2 = pin_column(2'h2);
            c3 = pin_column(2'h3);
            select_pins = 6'h00;
            for (i = 0; i < 6; i = i + 1) begin
                case (codes[2*i +: 2])
                    2'h0: select_pins[i] = c0[i];
                    2'h1: select_pins[i] = c1[i];
                    2'h2: select_pins[i] = c2[i];
                    default: select_pins[i] = c3[i];
                endcase
            end
        end
    endfunction

    // Interrupt events of this cycle
    always @* begin
        irq_set = {mode_flush | overrun_clr, overrun_event, match_now};
    end

    // APB handshake: no wait state; pready, registered read data and response come in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata  <= pwrite ? 32'h0 : next_rdata;
                pslverr <= next_err;
            end
        end
    end

    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_mode       <= `FCSD_M_STDBY;
            packet_mode     <= 1'b1;
            sync_config_reg <= `FCSD_RST_SYNC_CFG;
            sync_tx_pattern <= `FCSD_RST_SYNC_VAL;
            pin_map_reg_a   <= `FCSD_RST_MAP_A;
            pin_map_reg_b   <= `FCSD_RST_MAP_B;
            irq_enable      <= 3'h0;
        end else if (wr_access) begin
            case (paddr)
                `FCSD_OFF_MODE: begin
                    // Reserved mode codes are ignored rather than stored
                    if (new_mode <= `FCSD_M_RX)
                        chip_mode <= new_mode;
                    packet_mode <= pwdata[`FCSD_PKT_BIT];
                end
                `FCSD_OFF_SYNC_CFG: sync_config_reg <= pwdata[7:0];
                `FCSD_OFF_SYNC_HI:  sync_tx_pattern[63:32] <= pwdata;
                `FCSD_OFF_SYNC_LO:  sync_tx_pattern[31:0]  <= pwdata;
                `FCSD_OFF_MAP_A:    pin_map_reg_a <= pwdata[7:0];
                `FCSD_OFF_MAP_B:    pin_map_reg_b <= pwdata[3:0];
                `FCSD_OFF_IRQ_EN:   irq_enable <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Sync detector, flags, flush pulse and interrupt; every set beats its clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_shift         <= 64'h0;
            sync_match_flag    <= 1'b0;
            queue_overrun_flag <= 1'b0;
            fifo_flush         <= 1'b0;
            empty_prev         <= 1'b1;
            irq_status         <= 3'h0;
            irq                <= 1'b0;
            bit_sync_enable    <= 1'b1;
            sync_tx_length     <= 3'h3;
            gp_pin             <= 6'h00;
        end else begin
            empty_prev <= queue_empty;
            if (rx_bit_valid && sync_detect_enable && in_rx)
                sync_shift <= next_shift;
            if (match_now)
                sync_match_flag <= 1'b1;
            else if (match_clr)
                sync_match_flag <= 1'b0;
            if (overrun_event)
                queue_overrun_flag <= 1'b1;
            else if (overrun_clr)
                queue_overrun_flag <= 1'b0;
            fifo_flush <= mode_flush | overrun_clr;
            if (wr_access && paddr == `FCSD_OFF_IRQ_CLR)
                irq_status <= irq_set | (irq_status & ~pwdata[2:0]);
            else
                irq_status <= irq_set | irq_status;
            irq             <= |(irq_status & irq_enable);
            // Packet mode forces the bit synchronizer on; continuous relies on software
            bit_sync_enable <= packet_mode | sync_config_reg[`FCSD_BSYNC_BIT];
            sync_tx_length  <= sync_config_reg[`FCSD_SIZE_MSB:`FCSD_SIZE_LSB];
            gp_pin          <= select_pins(pin_codes);
        end
    end

endmodule

// ### tb/fcsd_properties.sv
// Checker for flush, sync flag and pin relations seen at the core's ports.
// Assumes it is bound into fcsd_core and that pclk is the only clock.
`timescale 1ns/1ps
module fcsd_properties (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // Register bus
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    // Stream and status
    input wire        rx_bit_valid,
    input wire        serial_data,
    // Watched outputs
    input wire        fifo_flush,
    input wire [2:0]  chip_mode,
    input wire        packet_mode,
    input wire        bit_sync_enable,
    input wire        sync_match_flag,
    input wire [5:0]  gp_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write to the mode register; old mode still on chip_mode
    sequence s_mode_wr;
        psel && penable && pready && pwrite && paddr == 12'h000;
    endsequence
    a_keep_swap: assert property (s_mode_wr ##0 (chip_mode < 3'h2 && pwdata[2:0] < 3'h2)
        |=> !fifo_flush) else $error("flush on standby sleep swap");
    a_keep_preload: assert property (s_mode_wr ##0 (chip_mode < 3'h2 && pwdata[2:0] == 3'h3)
        |=> !fifo_flush) else $error("flush on entry to transmit");
    a_flush_rx_entry: assert property (s_mode_wr ##0 (chip_mode < 3'h2 && pwdata[2:0] == 3'h5)
        |=> fifo_flush) else $error("no flush on entry to receive");
    a_flush_tx_exit: assert property (s_mode_wr ##0 (chip_mode == 3'h3 && pwdata[2:0] != 3'h3
        && pwdata[2:0] < 3'h6) |=> fifo_flush) else $error("no flush leaving transmit");
    a_keep_rx_exit: assert property (s_mode_wr ##0 (chip_mode == 3'h5 && pwdata[2:0] < 3'h2)
        |=> !fifo_flush) else $error("flush leaving receive");
    // A bit strobe in the same cycle may set the flag again, so it is excluded
    a_flag_rx_exit: assert property (s_mode_wr ##0 (chip_mode == 3'h5 && pwdata[2:0] != 3'h5
        && pwdata[2:0] < 3'h6 && !rx_bit_valid) |=> !sync_match_flag) else $error("flag kept after receive");
    a_flag_cause: assert property ($rose(sync_match_flag)
        |-> $past(rx_bit_valid) && $past(chip_mode) == 3'h5) else $error("flag without a received bit");
    a_flush_pulse: assert property (fifo_flush |=> !fifo_flush) else $error("flush longer than one cycle");
    a_pin2_data: assert property (!packet_mode && (chip_mode == 3'h5 || chip_mode == 3'h3)
        |=> gp_pin[2] == $past(serial_data)) else $error("pin 2 not serial data");
    a_bsync_packet: assert property (packet_mode
        |=> bit_sync_enable) else $error("bit sync off in packet mode");
    a_sleep_quiet: assert property (!packet_mode && chip_mode == 3'h0
        |=> gp_pin == 6'h00) else $error("pin active in sleep");
endmodule
bind fcsd_core fcsd_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .rx_bit_valid, .serial_data, .fifo_flush, .chip_mode, .packet_mode, .bit_sync_enable, .sync_match_flag,
    .gp_pin);

// ### tb/fcsd_host_model.sv
// Host side model: counts interrupt assertions as a microcontroller pin would.
// Assumes irq is a level output synchronous to pclk.
`timescale 1ns/1ps
module fcsd_host_model (
    // Clock and watched pin
    input  wire pclk,
    input  wire irq,
    // Interrupt assertions seen
    output int  irq_seen
);
    logic last_irq = 1'b0;
    initial irq_seen = 0;
    // Edge count, so a level held high is seen once
    always @(posedge pclk) begin
        if (irq === 1'b1 && last_irq !== 1'b1)
            irq_seen <= irq_seen + 1;
        last_irq <= irq;
    end
endmodule

// ### tb/tb.sv
// Testbench: APB host, status lines and bit stream; results are queued and checked by monitors.
// Assumes fcsd_core with fcsd_map.vh on the include path, the host model and the bound checker.
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] STREAM = 32'h0000a53c;
    logic        pclk, presetn, psel, penable, pwrite, rx_bit, rx_bit_valid, queue_write;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [16:0] st;
    logic [2:0]  cur;
    logic [17:0] e;
    logic [32:0] rd_q[$];
    logic [17:0] ob_q[$];
    wire  [31:0] prdata;
    wire  [5:0]  gp_pin;
    wire  [2:0]  chip_mode;
    wire         pready, pslverr, fifo_flush, sync_match_flag, queue_overrun_flag, irq;
    int          failures, check_count, cyc, irq_seen;
    logic [3:0]  seq [12] = '{4'h0, 4'h1, 4'h3, 4'h1, 4'h5, 4'h3, 4'h5, 4'h0, 4'h3, 4'h0, 4'h5, 4'h1};
    logic [4:0]  pm [5] = '{5'h05, 5'h03, 5'h0d, 5'h0b, 5'h1d};
    fcsd_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rx_bit, .rx_bit_valid, .queue_write, .bit_clock(st[16]), .serial_data(st[15]), .rx_timeout(st[14]),
        .temp_or_battery_alert(st[13]), .ref_clock_output(st[12]), .mode_settled(st[11]),
        .synth_locked(st[10]), .signal_or_preamble_detect(st[9]), .receiver_armed(st[8]),
        .transmitter_armed(st[7]), .queue_empty(st[6]), .queue_full(st[5]), .queue_threshold_hit(st[4]),
        .payload_available(st[3]), .checksum_valid(st[2]), .frame_sent(st[1]), .auto_sequence_active(st[0]),
        .fifo_flush, .chip_mode, .packet_mode(), .bit_sync_enable(), .sync_tx_length(),
        .sync_tx_pattern(), .sync_match_flag, .queue_overrun_flag, .irq, .gp_pin);
    fcsd_host_model u_host (.pclk, .irq, .irq_seen);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task cmp_data(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_sig(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Note for the negedge monitor: mask over {flush, sync, overrun, pins}, then value
    task ex(input logic [8:0] m, input logic [8:0] v);
        ob_q.push_back({m, v});
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic f);
        apb(a, 1'b1, d);
        ex(9'h100, {f, 8'h00});
    endtask
    task rd(input logic [11:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(a, 1'b0, 32'h0);
    endtask
    // Flush expected from old and new mode codes
    task set_mode(input logic [3:0] m);
        wr(12'h000, {28'h0, m}, (cur == 3'h3 && m[2:0] != 3'h3) || (cur < 3'h2 && m[2:0] == 3'h5)
            || (cur == 3'h5 && m[2:0] == 3'h3));
        cur = m[2:0];
    endtask
    // Sixteen zeros then the two sync bytes, earliest bit first, one bit each cycle
    task sbits(input logic hit);
        for (int i = 31; i >= 0; i--) begin
            rx_bit <= STREAM[i];
            rx_bit_valid <= 1'b1;
            @(posedge pclk);
            ex(9'h080, {1'b0, hit && i == 0, 7'h00});
        end
        rx_bit_valid <= 1'b0;
    endtask
    // Pin table for code 00, bit 4 of m selects data on pin 5 in packet receive
    function logic [5:0] pin_exp(input logic [4:0] m);
        pin_exp = {st[12], st[13], m[2:0] == 3'h5 ? st[14] : 1'b0, st[15], st[16], 1'b0};
        if (m[2:0] == 3'h3)
            pin_exp[0] = st[7];
        if (m[3])
            pin_exp[3:0] = {st[6], st[5], st[4], m[1] ? st[1] : st[3]};
        if (m[4])
            pin_exp[5] = st[15] & st[8];
    endfunction
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
            cmp_data({pslverr, prdata}, rd_q.pop_front());
    always @(negedge pclk)
        while (ob_q.size() > 0) begin
            e = ob_q.pop_front();
            cmp_sig({fifo_flush, sync_match_flag, queue_overrun_flag, gp_pin} & e[17:9], e[8:0]);
        end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test;
        end
    end
    initial begin
        {psel, penable, pwrite, rx_bit, rx_bit_valid, queue_write, presetn} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        st = 17'h0;
        cur = 3'h1;
        void'($urandom(77407));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h004, 33'h083);
        rd(12'h008, 33'h01010101);
        rd(12'h02c, {1'b1, 32'h0});
        foreach (seq[i]) set_mode(seq[i]);
        foreach (pm[i]) begin
            set_mode(pm[i][3:0]);
            if (pm[i][4])
                wr(12'h014, 32'h8, 1'b0);
            repeat (12) begin
                st <= 17'($urandom);
                @(posedge pclk);
                ex(9'h03f, {3'b0, pin_exp(pm[i])});
            end
        end
        st <= 17'h0;
        set_mode(4'h5);
        wr(12'h004, 32'hc1, 1'b0);
        wr(12'h008, 32'ha53c7e81, 1'b0);
        wr(12'h020, 32'h1, 1'b0);
        sbits(1'b1);
        rd(12'h01c, 33'h5);
        wr(12'h024, 32'h7, 1'b0);
        rd(12'h01c, 33'h0);
        st <= 17'h40;
        repeat (3) @(posedge pclk);
        ex(9'h080, 9'h000);
        st <= 17'h0;
        wr(12'h020, 32'h0, 1'b0);
        sbits(1'b1);
        set_mode(4'h1);
        ex(9'h080, 9'h000);
        wr(12'h004, 32'h41, 1'b0);
        set_mode(4'h5);
        sbits(1'b0);
        st <= 17'h20;
        queue_write <= 1'b1;
        @(posedge pclk);
        queue_write <= 1'b0;
        ex(9'h040, 9'h040);
        wr(12'h028, 32'h1, 1'b1);
        ex(9'h040, 9'h000);
        st <= 17'h0;
        cmp_data(33'(irq_seen), 33'h1);
        end_of_test;
    end
endmodule
